// >>> verilog/atcc_top.sv
`timescale 1ns/10ps
`default_nettype none
module atcc_top
   import atcc_pkg::*;
#(
   parameter int RATE0_CYC = atcc_pkg::ATCC_RATE0_CYC,
   parameter int RATE1_CYC = atcc_pkg::ATCC_RATE1_CYC,
   parameter int RATE2_CYC = atcc_pkg::ATCC_RATE2_CYC,
   parameter int RATE3_CYC = atcc_pkg::ATCC_RATE3_CYC
) (
   // Clock and reset
   input  wire logic       clock_i,
   input  wire logic       arst_n_i,
   // Register bank port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic [7:0]      reg_rdata_o,
   // Repeat rate from the neighbouring control register
   input  wire logic [1:0] auto_repeat_rate_i,
   // Sleep pin, high while asleep
   input  wire logic       sleep_input_pin_i,
   // Converter handshake
   output logic            conv_start_o,
   output logic [2:0]      conv_channel_o,
   output logic [1:0]      conv_pattern_o,
   output logic [2:0]      conv_step_o,
   output logic            conv_busy_o,
   input  wire logic       conv_done_i,
   // Comparator A
   input  wire logic       compare_a_out_i,
   output logic [6:0]      compare_a_count_o
);
   typedef struct packed {
      atcc_state_t state;
      logic [1:0]  pattern_sel;
      logic [2:0]  channel_sel;
      logic [1:0]  source_sel;
      logic        trig_bit;
      logic        edge_sel;
      logic [6:0]  cmpa_count;
      logic        cmpa_run;
      logic        cmpa_prev;
      logic        sleep_prev;
      logic [3:0]  step;
      logic [2:0]  cur_ch;
      logic        start;
   } atcc_st_t;
   atcc_st_t st_reg;
   atcc_st_t st_next;
   logic     auto_tick;
   logic     begin_seq;

   // Maps a channel code to the converted channel.
   function automatic logic [2:0] chan_map(input logic [2:0] code);
      chan_map = (code > ATCC_CH_LAST) ? ATCC_CH_LAST : code;
   endfunction : chan_map

   atcc_rate_timer #(
      .RATE0_CYC (RATE0_CYC),
      .RATE1_CYC (RATE1_CYC),
      .RATE2_CYC (RATE2_CYC),
      .RATE3_CYC (RATE3_CYC)
   ) u_timer (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .run_i    (st_reg.source_sel == ATCC_SRC_AUTO),
      .rate_i   (auto_repeat_rate_i),
      .tick_o   (auto_tick)
   );

   always_comb begin
      st_next = st_reg;
      st_next.start = 1'b0;
      st_next.sleep_prev = sleep_input_pin_i;
      st_next.cmpa_prev  = compare_a_out_i;
      begin_seq = 1'b0;
      case (st_reg.source_sel)
         ATCC_SRC_SOFT:  begin_seq = st_reg.trig_bit;
         ATCC_SRC_SLEEP: begin_seq = st_reg.sleep_prev && !sleep_input_pin_i;
         ATCC_SRC_AUTO:  begin_seq = auto_tick;
         default:        begin_seq = 1'b0;
      endcase
      if (reg_wr_i && reg_addr_i == ATCC_TRIG_CTRL_ADDR) begin
         st_next.trig_bit    = reg_wdata_i[ATCC_TRIG_BIT_POS];
         st_next.source_sel  = reg_wdata_i[ATCC_SRC_LSB +: 2];
         st_next.channel_sel = reg_wdata_i[ATCC_CH_LSB +: 3];
         st_next.pattern_sel = reg_wdata_i[ATCC_PAT_LSB +: 2];
      end
      if (reg_wr_i && reg_addr_i == ATCC_CMPA_CTRL_ADDR) begin
         st_next.edge_sel = reg_wdata_i[ATCC_CMPA_EDGE_POS];
      end
      case (st_reg.state)
         ATCC_IDLE: begin
            if (begin_seq) begin
               st_next.step   = 4'h0;
               st_next.cur_ch = (st_reg.pattern_sel == ATCC_PAT_SINGLE ||
                                 st_reg.pattern_sel == ATCC_PAT_REPEAT) ?
                                chan_map(st_reg.channel_sel) : 3'h0;
               st_next.start  = 1'b1;
               st_next.state  = ATCC_WAIT;
            end
         end
         ATCC_REQ: begin
            st_next.start = 1'b1;
            st_next.state = ATCC_WAIT;
         end
         ATCC_WAIT: begin
            if (conv_done_i) begin
               if (st_reg.pattern_sel == ATCC_PAT_SINGLE ||
                   st_reg.step == ATCC_SEQ_LEN - 4'h1) begin
                  st_next.state = ATCC_IDLE;
                  // A trigger written in the same cycle wins over the clear.
                  // self clear
                  if (st_reg.source_sel == ATCC_SRC_SOFT &&
                      !(reg_wr_i && reg_addr_i == ATCC_TRIG_CTRL_ADDR)) begin
                     st_next.trig_bit = 1'b0;
                  end
               end else begin
                  st_next.step  = st_reg.step + 4'h1;
                  if (st_reg.pattern_sel != ATCC_PAT_REPEAT) begin
                     st_next.cur_ch = st_reg.cur_ch + 3'h1;
                  end
                  st_next.state = ATCC_REQ;
               end
            end
         end
         default: st_next.state = ATCC_IDLE;
      endcase
      if (!st_reg.cmpa_run) begin
         if (st_reg.edge_sel ? (!st_reg.cmpa_prev && compare_a_out_i)
                             : (st_reg.cmpa_prev && !compare_a_out_i)) begin
            st_next.cmpa_run   = 1'b1;
            st_next.cmpa_count = 7'h00;
         end
      end else if (st_reg.cmpa_count == 7'h7F) begin
         st_next.cmpa_run = 1'b0;
      end else begin
         st_next.cmpa_count = st_reg.cmpa_count + 7'h01;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg       <= '0;
         st_reg.state <= ATCC_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // Read data is combinational on the address so a read needs no strobe.
   always_comb begin
      case (reg_addr_i)
         ATCC_TRIG_CTRL_ADDR:
            reg_rdata_o = {st_reg.pattern_sel, st_reg.channel_sel,
                           st_reg.source_sel, st_reg.trig_bit};
         ATCC_CMPA_CTRL_ADDR:
            reg_rdata_o = {st_reg.edge_sel, st_reg.cmpa_count};
         default:
            reg_rdata_o = ATCC_REG_RESET;
      endcase
   end

   assign conv_start_o      = st_reg.start;
   assign conv_channel_o    = st_reg.cur_ch;
   assign conv_pattern_o    = st_reg.pattern_sel;
   assign conv_step_o       = st_reg.step[2:0];
   assign conv_busy_o       = (st_reg.state != ATCC_IDLE);
   assign compare_a_count_o = st_reg.cmpa_count;
endmodule : atcc_top
`default_nettype wire

// >>> verilog/atcc_pkg.sv
package atcc_pkg;
   localparam logic [7:0] ATCC_TRIG_CTRL_ADDR = 8'h33;
   localparam logic [7:0] ATCC_CMPA_CTRL_ADDR = 8'h34;
   localparam logic [7:0] ATCC_REG_RESET      = 8'h00;
   localparam int ATCC_TRIG_BIT_POS  = 0;
   localparam int ATCC_SRC_LSB       = 1;
   localparam int ATCC_CH_LSB        = 3;
   localparam int ATCC_PAT_LSB       = 6;
   localparam int ATCC_CMPA_EDGE_POS = 7;
   localparam logic [1:0] ATCC_SRC_OFF   = 2'h0;
   localparam logic [1:0] ATCC_SRC_SOFT  = 2'h1;
   localparam logic [1:0] ATCC_SRC_SLEEP = 2'h2;
   localparam logic [1:0] ATCC_SRC_AUTO  = 2'h3;
   localparam logic [1:0] ATCC_PAT_SINGLE = 2'h0;
   localparam logic [1:0] ATCC_PAT_REPEAT = 2'h1;
   localparam logic [1:0] ATCC_PAT_SCAN   = 2'h2;
   localparam logic [1:0] ATCC_PAT_ACPWR  = 2'h3;
   localparam logic [2:0] ATCC_CH_LAST    = 3'h6;
   localparam logic [3:0] ATCC_SEQ_LEN    = 4'h8;
   localparam int ATCC_CLK_HZ = 10_000_000;
   // Repeat periods in microseconds.
   localparam int ATCC_RATE0_US = 500;
   localparam int ATCC_RATE1_US = 1000;
   localparam int ATCC_RATE2_US = 2000;
   localparam int ATCC_RATE3_US = 10000;
   localparam int ATCC_RATE0_CYC = ATCC_RATE0_US * (ATCC_CLK_HZ / 1_000_000);
   localparam int ATCC_RATE1_CYC = ATCC_RATE1_US * (ATCC_CLK_HZ / 1_000_000);
   localparam int ATCC_RATE2_CYC = ATCC_RATE2_US * (ATCC_CLK_HZ / 1_000_000);
   localparam int ATCC_RATE3_CYC = ATCC_RATE3_US * (ATCC_CLK_HZ / 1_000_000);
   typedef enum logic [2:0] {
      ATCC_IDLE = 3'b001,
      ATCC_REQ  = 3'b010,
      ATCC_WAIT = 3'b100
   } atcc_state_t;
endpackage : atcc_pkg

// >>> verilog/atcc_rate_timer.sv
`timescale 1ns/10ps
`default_nettype none
module atcc_rate_timer
   import atcc_pkg::*;
#(
   parameter int RATE0_CYC = ATCC_RATE0_CYC,
   parameter int RATE1_CYC = ATCC_RATE1_CYC,
   parameter int RATE2_CYC = ATCC_RATE2_CYC,
   parameter int RATE3_CYC = ATCC_RATE3_CYC
) (
   // Clock and reset
   input  wire logic       clock_i,
   input  wire logic       arst_n_i,
   // Control
   input  wire logic       run_i,
   input  wire logic [1:0] rate_i,
   // Tick
   output logic            tick_o
);
   typedef struct packed {
      logic [19:0] count;
      logic        tick;
   } atcc_tmr_t;
   atcc_tmr_t st_reg;
   atcc_tmr_t st_next;
   logic [19:0] period;

   // Auto repeat rate.
   // period select
   always_comb begin
      case (rate_i)
         2'h0:    period = 20'(RATE0_CYC);
         2'h1:    period = 20'(RATE1_CYC);
         2'h2:    period = 20'(RATE2_CYC);
         default: period = 20'(RATE3_CYC);
      endcase
   end

   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (!run_i) begin
         st_next.count = 20'h0_0000;
      end else if (st_reg.count >= period - 20'h0_0001) begin
         st_next.count = 20'h0_0000;
         st_next.tick  = 1'b1;
      end else begin
         st_next.count = st_reg.count + 20'h0_0001;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick_o = st_reg.tick;
endmodule : atcc_rate_timer
`default_nettype wire

// >>> verification/atcc_checker_sva.sv
`timescale 1ns/10ps
`default_nettype none
module atcc_checker (
   input wire logic       clock_i, arst_n_i, reg_wr_i,
   input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
   input wire logic       conv_start_o, conv_busy_o, conv_done_i,
   input wire logic [6:0] compare_a_count_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_wr_ctrl;
      reg_wr_i && reg_addr_i == 8'h33 ##1 reg_addr_i == 8'h33;
   endsequence
   sequence s_seq_end;
      conv_busy_o ##1 !conv_busy_o ##1 reg_addr_i == 8'h33;
   endsequence
   a_start_busy: assert property (conv_start_o |-> conv_busy_o)
      else $error("start outside a sequence");
   a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
      else $error("start longer than one cycle");
   a_done_advance: assert property (conv_busy_o && conv_done_i
      |-> ##[1:3] (conv_start_o || !conv_busy_o)) else $error("stalled");
   a_idle_quiet: assert property (reg_addr_i == 8'h33
      && reg_rdata_o[2:1] == 2'b00 && !conv_busy_o |=> !conv_start_o)
      else $error("start while off");
   a_trig_clear: assert property (s_seq_end |-> !reg_rdata_o[0])
      else $error("trigger bit kept");
   a_ctrl_readback: assert property (s_wr_ctrl
      |-> reg_rdata_o[7:1] == $past(reg_wdata_i[7:1]))
      else $error("control readback");
   a_unmapped_zero: assert property (reg_addr_i != 8'h33
      && reg_addr_i != 8'h34 |-> reg_rdata_o == 8'h00)
      else $error("unmapped read");
   a_count_step: assert property (compare_a_count_o != 7'h00
      && compare_a_count_o != 7'h7F |=> compare_a_count_o ==
      $past(compare_a_count_o) + 7'h01) else $error("count step");
endmodule : atcc_checker
bind atcc_top atcc_checker atcc_checker_inst (.clock_i, .arst_n_i,
   .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .conv_start_o,
   .conv_busy_o, .conv_done_i, .compare_a_count_o);
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic       clock_i = 1'b0, arst_n_i = 1'b0, reg_wr_i = 1'b0;
   logic       sleep_input_pin_i = 1'b0, conv_done_i = 1'b0;
   logic       compare_a_out_i = 1'b1, conv_start_o, conv_busy_o;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic [1:0] auto_repeat_rate_i = 2'h0, conv_pattern_o;
   logic [2:0] conv_channel_o, conv_step_o, dly = 3'h0;
   logic [6:0] compare_a_count_o;
   int         fails = 0, checked = 0, starts = 0;
   always #50 clock_i = ~clock_i;
   atcc_top #(.RATE0_CYC(20), .RATE1_CYC(30), .RATE2_CYC(40),
      .RATE3_CYC(50)) atcc_top_inst (.clock_i, .arst_n_i, .reg_addr_i,
      .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .auto_repeat_rate_i,
      .sleep_input_pin_i, .conv_start_o, .conv_channel_o, .conv_pattern_o,
      .conv_step_o, .conv_busy_o, .conv_done_i, .compare_a_out_i,
      .compare_a_count_o);
   // The converter answers each start three cycles later.
   always @(negedge clock_i) begin
      conv_done_i <= dly[2];
      dly <= {dly[1:0], conv_start_o};
   end
   // Counted on the falling edge, where the registered start has settled.
   always @(negedge clock_i) if (conv_start_o) starts++;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clock_i);
      reg_wr_i = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clock_i);
      reg_addr_i = a;
      #1 chk(reg_rdata_o, exp);
   endtask : rd
   task automatic wait_for(ref logic s, input logic v);
      int k;
      k = 0;
      do begin
         @(negedge clock_i);
         k++;
      end while (s !== v && k < 2000);
      if (k >= 2000) chk(8'h00, 8'h01);
   endtask : wait_for
   task automatic t_off;
      wr(8'h33, 8'h01);
      sleep_input_pin_i = 1'b1;
      repeat (10) @(negedge clock_i);
      sleep_input_pin_i = 1'b0;
      repeat (30) @(negedge clock_i);
      chk(8'(starts), 8'h00);
      rd(8'h35, 8'h00);
      wr(8'h33, 8'h00);
      $display("off mode done");
   endtask : t_off
   task automatic t_soft;
      logic [1:0] p;
      logic [7:0] ch;
      for (int i = 0; i < 12; i++) begin
         p = (i < 8) ? 2'h0 : 2'(i);
         ch = (i % 8 == 7) ? 8'h06 : 8'(i % 8);
         starts = 0;
         wr(8'h33, {p, 3'(i), 3'h3});
         wait_for(conv_start_o, 1'b1);
         chk(8'(conv_channel_o), p[1] ? 8'h00 : ch);
         chk(8'(conv_step_o), 8'h00);
         wait_for(conv_busy_o, 1'b0);
         chk(8'(starts), p == 2'h0 ? 8'h01 : 8'h08);
         chk(8'(conv_channel_o), p[1] ? 8'h07 : ch);
         chk(8'(conv_step_o), p == 2'h0 ? 8'h00 : 8'h07);
         chk(8'(conv_pattern_o), 8'(p));
         rd(8'h33, {p, 3'(i), 3'h2});
      end
      $display("software trigger done");
   endtask : t_soft
   task automatic t_sleep;
      starts = 0;
      wr(8'h33, 8'h04);
      sleep_input_pin_i = 1'b1;
      repeat (10) @(negedge clock_i);
      chk(8'(starts), 8'h00);
      sleep_input_pin_i = 1'b0;
      wait_for(conv_busy_o, 1'b1);
      wait_for(conv_busy_o, 1'b0);
      chk(8'(starts), 8'h01);
      $display("sleep exit done");
   endtask : t_sleep
   task automatic t_auto;
      int k;
      for (int r = 0; r < 4; r++) begin
         auto_repeat_rate_i = 2'(r);
         wr(8'h33, 8'h06);
         wait_for(conv_start_o, 1'b1);
         k = 0;
         do begin
            @(negedge clock_i);
            k++;
         end while (conv_start_o !== 1'b1 && k < 200);
         chk(8'(k), 8'(20 + 10 * r));
         wr(8'h33, 8'h00);
         wait_for(conv_busy_o, 1'b0);
      end
      $display("auto repeat done");
   endtask : t_auto
   task automatic t_cmp;
      int k;
      k = 0;
      wr(8'h34, 8'h00);
      compare_a_out_i = 1'b0;
      while (compare_a_count_o !== 7'h7F && k < 300) begin
         @(negedge clock_i);
         k++;
      end
      chk(8'(k), 8'h80);
      repeat (3) @(negedge clock_i);
      rd(8'h34, 8'h7F);
      wr(8'h34, 8'h80);
      rd(8'h34, 8'hFF);
      compare_a_out_i = 1'b1;
      repeat (6) @(negedge clock_i);
      chk(8'(compare_a_count_o), 8'h05);
      $display("comparator counter done");
   endtask : t_cmp
   task automatic wrap_up;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   initial begin
      #1_000_000;
      fails++;
      wrap_up;
   end
   initial begin
      repeat (5) @(negedge clock_i);
      arst_n_i = 1'b1;
      rd(8'h33, 8'h00);
      rd(8'h34, 8'h00);
      t_off;
      t_soft;
      t_sleep;
      t_auto;
      t_cmp;
      wrap_up;
   end
endmodule : testbench
`default_nettype wire
